// ===== bench/autoneg_ability_regs_asserts.sv
// port checker for the auto-negotiation ability bank
`timescale 1ns/1ns
module autoneg_ability_regs_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic link_up,
  input wire logic [15:0] adv_code_word,
  input wire logic adv_1000_full,
  input wire logic adv_1000_half,
  input wire logic an_run,
  input wire logic an_restart
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // link loss must lead to a fresh advertisement within a short bound
  sequence link_lost;
    $fell(link_up);
  endsequence
  sequence restart_seen;
    ##[1:3] an_restart;
  endsequence
  loss_applies_a: assert property (link_lost |-> restart_seen)
    else $error("no restart after link loss");
  read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  forced_excl_a: assert property (!(adv_1000_full && adv_1000_half))
    else $error("both 1000 duplex modes advertised");
  forced_run_a: assert property (adv_1000_full || adv_1000_half |-> an_run)
    else $error("forced 1000 without negotiation");
  forced_mask_a: assert property (adv_1000_full || adv_1000_half |->
    adv_code_word[7:5] == 3'h0) else $error("10/100 bits leak in forced 1000");
  restart_pulse_a: assert property (an_restart |=> !an_restart)
    else $error("restart longer than one cycle");
endmodule : autoneg_ability_regs_asserts

bind autoneg_ability_regs autoneg_ability_regs_asserts chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .link_up(link_up),
  .adv_code_word(adv_code_word), .adv_1000_full(adv_1000_full),
  .adv_1000_half(adv_1000_half), .an_run(an_run), .an_restart(an_restart));

// ===== bench/copper_autoneg_ability_regs_tb.sv
// self-checking bench for the auto-negotiation ability bank
`timescale 1ns/1ns
`include "autoneg_map.svh"
module copper_autoneg_ability_regs_tb
  import autoneg_pkg::*;
;
  localparam logic [7:0] A_CTRL = `IDX_CTRL << 2;
  localparam logic [7:0] A_ADV = `IDX_ADVERTISE << 2;
  localparam logic [7:0] A_LP = `IDX_PARTNER << 2;
  localparam logic [7:0] A_STAT = `IDX_STATUS << 2;
  logic aclk, aresetn, aw_v, aw_rdy, w_v, w_rdy, b_v, b_rdy, ar_v, ar_rdy, r_v, r_rdy;
  logic link_up, pg_v, f_full, f_half, an_run, an_rst, pdn;
  logic [7:0] aw_a, ar_a;
  logic [31:0] w_d, r_d;
  logic [1:0] b_resp, r_resp;
  logic [15:0] cw, adv;
  int errors, n_tests;

  initial begin
    aclk = 0;
    forever #10 aclk = ~aclk;
  end

  autoneg_ability_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_rdy), .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0), .s_axi_wvalid(w_v),
    .s_axi_wready(w_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_bvalid(b_v),
    .s_axi_bready(b_rdy), .s_axi_bresp(b_resp), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
    .s_axi_araddr(ar_a), .s_axi_arprot(3'h0), .s_axi_rvalid(r_v), .s_axi_rready(r_rdy),
    .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .link_up(link_up), .rx_page_valid(pg_v),
    .rx_code_word(cw), .adv_code_word(adv), .adv_1000_full(f_full), .adv_1000_half(f_half),
    .an_run(an_run), .an_restart(an_rst), .power_down(pdn));
  link_partner_model lp (.aclk(aclk), .link_up(link_up), .rx_page_valid(pg_v),
    .rx_code_word(cw));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] e);
    logic pa, pw;
    pa = 1;
    pw = 1;
    aw_a <= a;
    w_d <= {16'h0000, d};
    aw_v <= 1;
    w_v <= 1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && aw_rdy) begin
        pa = 0;
        aw_v <= 0;
      end
      if (pw && w_rdy) begin
        pw = 0;
        w_v <= 0;
      end
    end
    // bready held back now and then so the response must stand
    repeat ($urandom_range(2)) @(posedge aclk);
    b_rdy <= 1;
    do @(posedge aclk); while (b_v !== 1'b1);
    b_rdy <= 0;
    chk(32'(b_resp), 32'(e));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] e);
    ar_a <= a;
    ar_v <= 1;
    do @(posedge aclk); while (ar_rdy !== 1'b1);
    ar_v <= 0;
    // rready held back now and then so the read data must stand
    repeat ($urandom_range(2)) @(posedge aclk);
    r_rdy <= 1;
    do @(posedge aclk); while (r_v !== 1'b1);
    r_rdy <= 0;
    chk(r_d, exp);
    chk(32'(r_resp), 32'(e));
  endtask : rd

  task give_verdict;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // hang guard, far beyond the few hundred cycles of the run
  initial begin
    #200000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict;
  end

  initial begin
    logic [2:0] ab, eff;
    logic [4:0] sel;
    logic [15:0] w;
    logic d;
    {aresetn, aw_v, w_v, b_rdy, ar_v, r_rdy} = '0;
    {aw_a, ar_a, w_d} = '0;
    eff = 3'h7;
    void'($urandom(32'hD10959A3));
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    rd(A_ADV, 32'h0000_00E1, `RESP_OKAY);
    rd(A_LP, 32'h0, `RESP_OKAY);
    chk(32'(adv), 32'h0000_00E1);
    rd(8'h20, 32'h0, `RESP_SLVERR);
    wr(A_LP, 16'hFFFF, `RESP_SLVERR);
    rd(A_LP, 32'h0, `RESP_OKAY);
    // one apply event per pass: restart, soft reset, link loss, exit of each power-down bit
    for (int k = 0; k < 5; k++) begin
      ab = eff ^ (3'($urandom) | 3'h1);
      sel = 5'($urandom);
      w = {8'h00, ab, sel};
      wr(A_ADV, w, `RESP_OKAY);
      rd(A_ADV, {16'h0, w}, `RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk(32'(adv), {24'h0, eff, sel});
      case (k)
        0: wr(A_CTRL, 16'h1340, `RESP_OKAY);
        1: wr(A_CTRL, 16'h9140, `RESP_OKAY);
        2: lp.drop_link(3);
        default: begin
          wr(A_CTRL, (k == 3) ? 16'h1940 : 16'h1144, `RESP_OKAY);
          repeat (2) @(posedge aclk);
          chk(32'(pdn), 32'h1);
          wr(A_CTRL, 16'h1140, `RESP_OKAY);
        end
      endcase
      repeat (4) @(posedge aclk);
      eff = ab;
      chk(32'(adv), {24'h0, eff, sel});
      chk(32'(pdn), 32'h0);
    end
    // pages, then idle cycles with the inverted word that must not load
    for (int k = 0; k < 6; k++) begin
      w = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'($urandom);
      lp.send_page(w);
      repeat (3) @(posedge aclk);
      rd(A_LP, {16'h0, w}, `RESP_OKAY);
    end
    // forced 1000 with both duplex settings
    for (int k = 0; k < 2; k++) begin
      d = k[0];
      wr(A_CTRL, {7'h00, d, 8'h40}, `RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk(32'({an_run, f_full, f_half, adv[7:5]}), 32'({1'b1, d, !d, 3'h0}));
      rd(A_STAT, {16'h0, 8'hE0 | {6'h00, d, !d}, 8'h00}, `RESP_OKAY);
    end
    give_verdict;
  end
endmodule : copper_autoneg_ability_regs_tb

// ===== bench/link_partner_model.sv
// remote link partner: link level and received base pages
`timescale 1ns/1ns
module link_partner_model (
  input wire logic aclk,
  output logic link_up,
  output logic rx_page_valid,
  output logic [15:0] rx_code_word
);
  initial begin
    link_up = 1'b1;
    rx_page_valid = 1'b0;
    rx_code_word = 16'hA5A5;
  end
  // word is inverted after the page so a late load cannot pass
  task automatic send_page(input logic [15:0] w);
    rx_code_word <= w;
    rx_page_valid <= 1'b1;
    @(posedge aclk);
    rx_page_valid <= 1'b0;
    rx_code_word <= ~w;
  endtask : send_page
  // link loss event
  task automatic drop_link(input int n);
    link_up <= 1'b0;
    repeat (n) @(posedge aclk);
    link_up <= 1'b1;
  endtask : drop_link
endmodule : link_partner_model

// ===== rtl/advert_pending.sv
// pending and effective copies of the advertised 10/100 ability bits
`timescale 1ns/1ns
`include "autoneg_map.svh"
module advert_pending
  import autoneg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [2:0] wr_bits,
  input wire logic apply,
  output logic [2:0] pending_r,
  output logic [2:0] effective_r,
  output logic differ_r
);

  // software writes land here and wait
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_r <= `ADV_ABIL_RESET; // R05
    end else if (wr_en) begin
      pending_r <= wr_bits; // R01
    end
  end

  // the ability engine only ever sees this copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      effective_r <= `ADV_ABIL_RESET; // R05
    end else if (apply) begin
      // a write in the same cycle is taken along, so nothing is lost
      effective_r <= wr_en ? wr_bits : pending_r; // R01
    end
  end

  // flag that software has an unapplied change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      differ_r <= 1'b0;
    end else if (apply) begin
      differ_r <= 1'b0;
    end else if (wr_en) begin
      differ_r <= (wr_bits != effective_r);
    end
  end

endmodule : advert_pending

// ===== rtl/autoneg_ability_regs.sv
// auto-negotiation advertisement and partner ability registers behind an axi4-lite slave
// Function
// (R01) ability writes wait for reset, restart, link loss
// (R02) leaving power down also applies pending writes
// (R03) forced 1000 keeps negotiation, advertises duplex
// (R04) forced 1000 ignores 10/100 and 1000 bits
// (R05) bits 7:5 advertise, reset one, refreshed
// (R06) selector resets to 802.3, kept on reset
// (R07) partner bit 15 is next page ability
// (R08) partner bit 14 is acknowledge
// (R09) partner bit 13 is remote fault
// (R10) partner bit 12 shown unchanged
// (R11) partner bit 11 is asymmetric pause
// (R12) partner bit 10 is pause capable
// (R13) partner bits 9:5 are technology abilities
// (R14) partner bits 4:0 are received selector
// (R15) partner word loaded whole on page accept
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ns
`include "autoneg_map.svh"
module autoneg_ability_regs
  import autoneg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // link side
  input wire logic link_up,
  input wire logic rx_page_valid,
  input wire logic [15:0] rx_code_word,
  output logic [15:0] adv_code_word,
  output logic adv_1000_full,
  output logic adv_1000_half,
  output logic an_run,
  output logic an_restart,
  output logic power_down
);

  // write channel holding state
  logic aw_full_r;
  logic w_full_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  // read channel state
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  // control and link state
  reg16_t ctrl_r;
  logic [4:0] selector_r;
  logic link_prev_r;
  logic pd_prev_r;
  logic sw_reset_r;
  logic restart_r;
  logic [15:0] adv_word_r;
  logic adv_full_r;
  logic adv_half_r;
  logic an_run_r;
  logic an_restart_r;
  logic power_down_r;
  // decode and write strobes
  logic wr_go;
  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  logic [15:0] wr_mask;
  logic [15:0] wr_val;
  logic wr_ctrl;
  logic wr_adv;
  logic [15:0] ctrl_wval;
  logic [15:0] adv_wval;
  logic pd_now;
  logic forced_1000;
  logic apply;
  // sub-block outputs
  logic [2:0] pending_abil;
  logic [2:0] effective_abil;
  logic pending_differ;
  reg16_t partner_word;
  logic [15:0] adv_readback;
  logic [15:0] status_word;

  // byte-lane merge of a write into a 16-bit register image
  function automatic logic [15:0] merge_bytes(input logic [15:0] old_val,
    input logic [15:0] new_val, input logic [15:0] mask);
    return (old_val & ~mask) | (new_val & mask);
  endfunction : merge_bytes

  // high at the last sample and low now
  function automatic logic fell_now(input logic prev_lvl, input logic cur_lvl);
    return prev_lvl && !cur_lvl;
  endfunction : fell_now

  // write proceeds once both address and data are held and no response waits
  assign wr_go = aw_full_r && w_full_r && !bvalid_r;
  assign wr_sel = decode_addr(awaddr_r);
  assign wr_mask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign wr_val = wdata_r[15:0];
  assign wr_ctrl = wr_go && (wr_sel == SEL_CTRL);
  assign wr_adv = wr_go && (wr_sel == SEL_ADVERTISE);
  assign ctrl_wval = merge_bytes(ctrl_r, wr_val, wr_mask);
  assign adv_wval = merge_bytes(adv_readback, wr_val, wr_mask);

  // upper advertisement bits are not kept and read as zero
  assign adv_readback = {8'h00, pending_abil, selector_r};

  // write address channel; taken independently of the data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      awaddr_r <= 8'h00;
      awready_r <= 1'b0;
    end else if (s_axi_awvalid && awready_r) begin
      aw_full_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
      awready_r <= 1'b0;
    end else if (wr_go) begin
      aw_full_r <= 1'b0;
    end else if (!aw_full_r && !bvalid_r) begin
      awready_r <= 1'b1;
    end
  end

  // write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      wready_r <= 1'b0;
    end else if (s_axi_wvalid && wready_r) begin
      w_full_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
      wready_r <= 1'b0;
    end else if (wr_go) begin
      w_full_r <= 1'b0;
    end else if (!w_full_r && !bvalid_r) begin
      wready_r <= 1'b1;
    end
  end

  // write response; read-only and unmapped targets answer slverr
  // one write in flight keeps the response order trivial
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= (wr_ctrl || wr_adv) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready && bvalid_r) begin
      bvalid_r <= 1'b0;
    end
  end

  // control register; reset and restart bits self clear and read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= ctrl_wval;
      ctrl_r[`CTRL_SW_RESET] <= 1'b0;
      ctrl_r[`CTRL_AN_RESTART] <= 1'b0;
    end
  end

  // one-cycle pulses from writing one to the self-clearing bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_reset_r <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      sw_reset_r <= wr_ctrl && ctrl_wval[`CTRL_SW_RESET];
      restart_r <= wr_ctrl && ctrl_wval[`CTRL_AN_RESTART];
    end
  end

  // selector writes take effect at once; software reset leaves it alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      selector_r <= `ADV_SEL_RESET; // R06
    end else if (wr_adv) begin
      selector_r <= adv_wval[`ADV_SEL_MSB:`ADV_SEL_LSB];
    end
  end

  // previous levels for link loss and power-down exit detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_prev_r <= 1'b0;
      pd_prev_r <= 1'b0;
    end else begin
      link_prev_r <= link_up;
      pd_prev_r <= pd_now;
    end
  end

  // either power-down bit keeps the port down
  assign pd_now = ctrl_r[`CTRL_POWER_DOWN] || ctrl_r[`CTRL_POWER_DOWN_ALT];

  // any of the four events releases the pending abilities
  // events landing in one cycle merge into a single restart
  assign apply = sw_reset_r || restart_r // R01 R05
    || fell_now(link_prev_r, link_up) // R01
    || fell_now(pd_prev_r, pd_now); // R02

  // speed select 01 (bit 6 set, bit 13 clear) means 1000 mb/s; forced only when negotiation is off
  assign forced_1000 = !ctrl_r[`CTRL_AN_ENABLE] && ctrl_r[`CTRL_SPEED_LSB]
    && !ctrl_r[`CTRL_SPEED_MSB]; // R03

  // pending store for bits 7:5
  advert_pending u_pending (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_adv),
    .wr_bits(adv_wval[`ADV_ABIL_MSB:`ADV_ABIL_LSB]),
    .apply(apply),
    .pending_r(pending_abil),
    .effective_r(effective_abil),
    .differ_r(pending_differ)
  );

  // partner base page capture
  partner_capture u_partner (
    .aclk(aclk),
    .aresetn(aresetn),
    .page_valid(rx_page_valid),
    .code_word(rx_code_word),
    .partner_r(partner_word)
  );

  // advertised word to the negotiation engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adv_word_r <= {8'h00, `ADV_ABIL_RESET, `ADV_SEL_RESET};
      adv_full_r <= 1'b0;
      adv_half_r <= 1'b0;
    end else if (forced_1000) begin
      // 10/100 abilities dropped, only the forced duplex goes out
      adv_word_r <= {8'h00, 3'h0, selector_r}; // R04
      adv_full_r <= ctrl_r[`CTRL_DUPLEX]; // R03
      adv_half_r <= !ctrl_r[`CTRL_DUPLEX]; // R03
    end else begin
      adv_word_r <= {8'h00, effective_abil, selector_r}; // R05 R06
      adv_full_r <= 1'b0;
      adv_half_r <= 1'b0;
    end
  end

  // negotiation run, restart and power-down levels for the engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      an_run_r <= 1'b0;
      an_restart_r <= 1'b0;
      power_down_r <= 1'b0;
    end else begin
      an_run_r <= ctrl_r[`CTRL_AN_ENABLE] || forced_1000; // R03
      an_restart_r <= apply;
      power_down_r <= pd_now;
    end
  end

  // read path; the read-back of register 4 shows what software wrote
  assign rd_sel = decode_addr(s_axi_araddr);

  // own status view of the link and negotiation levels
  assign status_word = {link_up, an_run_r, forced_1000, pending_differ, 2'h0, adv_full_r,
    adv_half_r, 8'h00};

  // answer one cycle after the address; arready stays low while data waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= `RESP_OKAY;
      if (rd_sel == SEL_CTRL) begin
        rdata_r <= {16'h0000, ctrl_r};
      end else if (rd_sel == SEL_STATUS) begin
        rdata_r <= {16'h0000, status_word};
      end else if (rd_sel == SEL_ADVERTISE) begin
        rdata_r <= {16'h0000, adv_readback};
      end else if (rd_sel == SEL_PARTNER) begin
        rdata_r <= {16'h0000, partner_word}; // R07 R08 R09 R10 R11 R12 R13 R14
      end else begin
        rdata_r <= 32'h0000_0000;
        rresp_r <= `RESP_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end else if (!rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign adv_code_word = adv_word_r;
  assign adv_1000_full = adv_full_r;
  assign adv_1000_half = adv_half_r;
  assign an_run = an_run_r;
  assign an_restart = an_restart_r;
  assign power_down = power_down_r;

endmodule : autoneg_ability_regs

// ===== rtl/autoneg_map.svh
// register offsets, field positions, reset values for the auto-negotiation ability bank
`ifndef AUTONEG_MAP_SVH
`define AUTONEG_MAP_SVH

// register indices; byte address is four times the index
`define IDX_CTRL 8'h00
`define IDX_STATUS 8'h01
`define IDX_ADVERTISE 8'h04
`define IDX_PARTNER 8'h05

// control register fields
`define CTRL_SW_RESET 15
`define CTRL_SPEED_MSB 13
`define CTRL_AN_ENABLE 12
`define CTRL_POWER_DOWN 11
`define CTRL_AN_RESTART 9
`define CTRL_DUPLEX 8
`define CTRL_SPEED_LSB 6
`define CTRL_POWER_DOWN_ALT 2

// control register reset value: auto-negotiation on, full duplex, 1000 select
`define CTRL_RESET 16'h1140

// advertisement register fields
`define ADV_ABIL_MSB 7
`define ADV_ABIL_LSB 5
`define ADV_SEL_MSB 4
`define ADV_SEL_LSB 0
`define ADV_ABIL_RESET 3'h7
`define ADV_SEL_RESET 5'h01

// partner register reset value
`define PARTNER_RESET 16'h0000

// status register fields
`define STAT_LINK 15
`define STAT_AN_RUN 14
`define STAT_FORCED_1000 13
`define STAT_PENDING 12
`define STAT_ADV_1000_FULL 9
`define STAT_ADV_1000_HALF 8

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== rtl/autoneg_pkg.sv
// shared types for the auto-negotiation ability bank
`include "autoneg_map.svh"
package autoneg_pkg;

  typedef logic [15:0] reg16_t;

  typedef enum logic [2:0] {
    SEL_CTRL = 3'b000,
    SEL_STATUS = 3'b001,
    SEL_ADVERTISE = 3'b010,
    SEL_PARTNER = 3'b011,
    SEL_NONE = 3'b100
  } reg_sel_t;

  // word-aligned byte address to register select
  function automatic reg_sel_t decode_addr(input logic [7:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr[1:0] != 2'h0) begin
      sel = SEL_NONE;
    end else if (addr[7:2] == 6'(`IDX_CTRL)) begin
      sel = SEL_CTRL;
    end else if (addr[7:2] == 6'(`IDX_STATUS)) begin
      sel = SEL_STATUS;
    end else if (addr[7:2] == 6'(`IDX_ADVERTISE)) begin
      sel = SEL_ADVERTISE;
    end else if (addr[7:2] == 6'(`IDX_PARTNER)) begin
      sel = SEL_PARTNER;
    end
    return sel;
  endfunction : decode_addr

endpackage : autoneg_pkg

// ===== rtl/partner_capture.sv
// holds the link partner base page code word
`timescale 1ns/1ns
`include "autoneg_map.svh"
module partner_capture
  import autoneg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic page_valid,
  input wire logic [15:0] code_word,
  output reg16_t partner_r
);

  // whole word loaded at once so software never sees a torn page
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      partner_r <= `PARTNER_RESET; // R07 R14
    end else if (page_valid) begin
      partner_r <= code_word; // R15 R07 R08 R09 R10 R11 R12 R13 R14
    end
  end

endmodule : partner_capture
